// [hdl/cssc_pkg.sv]
// What this block does
// - four-bit source field picks crystal, full-swing, low-freq, RC or external
// - a fuse bit at one means unprogrammed, zero means programmed
// - defaults: calibrated RC, start-up code 10, divide-by-eight programmed
// - internal reset stays asserted a time-out after other resets release
// - time-out counts watchdog cycles: 0, 4096 or 8192 by fuse setting
// - ripple counter on selected oscillator holds reset until count elapsed
// - start-up counts span 6 cycles external up to 32K low-freq crystal
// - reset start uses time-out plus start-up; deep-sleep wake only start-up
// - core, peripheral, program memory, async timer, converter gated apart
// - async timer clock runs from its own source, also while sleeping
// - asynchronous detectors are told when the peripheral clock is halted
// - program memory clock follows core clock; core halt stops core work
// - divide-by-eight programmed divides the system clock by eight
package cssc_pkg;

  // decoded oscillator family
  typedef enum logic [2:0] {
    SRC_LOW_POWER  = 3'b000,
    SRC_FULL_SWING = 3'b001,
    SRC_LOW_FREQ   = 3'b010,
    SRC_RC_128K    = 3'b011,
    SRC_RC_CALIB   = 3'b100,
    SRC_EXTERNAL   = 3'b101
  } cssc_src_type;

  // start-up sequencer
  typedef enum logic [2:0] {
    ST_HOLD    = 3'b000,
    ST_TIMEOUT = 3'b001,
    ST_STARTUP = 3'b010,
    ST_RUN     = 3'b011,
    ST_SLEEP   = 3'b100,
    ST_WAKE    = 3'b101
  } cssc_state_type;

  // sleep mode codes on the sleep_mode port
  localparam logic [2:0] SLP_IDLE       = 3'h0;
  localparam logic [2:0] SLP_ADC_NR     = 3'h1;
  localparam logic [2:0] SLP_POWER_DOWN = 3'h2;
  localparam logic [2:0] SLP_POWER_SAVE = 3'h3;
  localparam logic [2:0] SLP_STANDBY    = 3'h6;

  // source field codes and ranges
  localparam logic [3:0] CFG_SRC_EXT      = 4'h0;
  localparam logic [3:0] CFG_SRC_RESERVED = 4'h1;
  localparam logic [3:0] CFG_SRC_RC_CALIB = 4'h2;
  localparam logic [3:0] CFG_SRC_RC_128K  = 4'h3;
  localparam logic [3:0] CFG_SRC_LF_MIN   = 4'h4;
  localparam logic [3:0] CFG_SRC_FS_MIN   = 4'h6;
  localparam logic [3:0] CFG_SRC_LP_MIN   = 4'h8;

  // shipped defaults
  localparam logic [3:0] CFG_SRC_DEFAULT  = 4'h2;
  localparam logic [1:0] CFG_SUT_DEFAULT  = 2'h2;
  localparam logic       CFG_DIV8_DEFAULT = 1'b0;
  localparam logic       FUSE_PROGRAMMED  = 1'b0;

  // counts in oscillator cycles
  localparam int         CNT_W      = 16;
  localparam logic [15:0] TOUT_NONE  = 16'h0000;
  localparam logic [15:0] TOUT_SHORT = 16'h1000;
  localparam logic [15:0] TOUT_LONG  = 16'h2000;
  localparam logic [15:0] SU_EXT     = 16'h0006;
  localparam logic [15:0] SU_258     = 16'h0102;
  localparam logic [15:0] SU_1K      = 16'h0400;
  localparam logic [15:0] SU_16K     = 16'h4000;
  localparam logic [15:0] SU_32K     = 16'h8000;
  localparam logic [2:0]  DIV_LAST   = 3'h7;

endpackage

// [hdl/cssc_edge_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module cssc_edge_counter #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // oscillator pin, foreign domain
  input  wire logic             osc_in,
  // count control
  input  wire logic             clear,
  input  wire logic [CNT_W-1:0] target,
  // results
  output logic                  edge_pulse,
  output logic                  done
);

  logic             sync1_q;
  logic             sync2_q;
  logic             prev_q;
  logic [CNT_W-1:0] cnt_q;

  // two-flop synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= osc_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // rising edge of the oscillator, one cycle wide
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= sync2_q & ~prev_q;
    end
  end

  // ripple count of oscillator edges; saturates at target
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else if (edge_pulse && !done) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done = (cnt_q >= target);

endmodule
`default_nettype wire

// [hdl/cssc_clock_startup.sv]
`timescale 1ns/1ps
`default_nettype none
module cssc_clock_startup (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // reset from the other sources, asynchronous pin
  input  wire logic       other_reset_n,
  // configuration fuses, static
  input  wire logic [3:0] clock_source_select,
  input  wire logic [1:0] startup_time_select,
  input  wire logic       divide_by_eight_setting,
  input  wire logic       async_use_ext,
  // oscillator outputs, asynchronous pins
  input  wire logic       xtal_osc,
  input  wire logic       lf_xtal_osc,
  input  wire logic       rc_calib_osc,
  input  wire logic       rc_128k_osc,
  input  wire logic       ext_clock,
  input  wire logic       watchdog_osc,
  // sleep control from the core, same clock
  input  wire logic       sleep_req,
  input  wire logic [2:0] sleep_mode,
  input  wire logic       wake_req,
  // reset and clock domain enables
  output logic            internal_reset_n,
  output logic            core_clock,
  output logic            program_memory_clock,
  output logic            peripheral_clock,
  output logic            async_timer_clock,
  output logic            converter_clock,
  // status
  output logic            peripheral_clock_halted,
  output logic [2:0]      selected_source
);

  cssc_pkg::cssc_state_type state_q;
  cssc_pkg::cssc_state_type state_d;
  cssc_pkg::cssc_src_type   src_q;
  logic                     div_on_q;
  logic [2:0]               mode_q;
  logic [15:0]              tout_q;
  logic [15:0]              su_q;
  logic [2:0]               div_q;
  logic                     rst_s1_q;
  logic                     rst_s2_q;
  logic                     osc_mux;
  logic                     async_mux;
  logic                     wdt_done;
  logic                     osc_edge;
  logic                     osc_done;
  logic                     async_edge;
  logic                     running;
  logic                     tick;
  logic                     io_on;
  logic                     adc_on;
  logic                     deep;

  //////////////////////////////////////////////////////////////////////////
  // fuse decode

  // reserved code falls back to the calibrated RC, which always starts
  function automatic cssc_pkg::cssc_src_type decode_src(
    input logic [3:0] c);
    if (c >= cssc_pkg::CFG_SRC_LP_MIN) begin
      decode_src = cssc_pkg::SRC_LOW_POWER;
    end else if (c >= cssc_pkg::CFG_SRC_FS_MIN) begin
      decode_src = cssc_pkg::SRC_FULL_SWING;
    end else if (c >= cssc_pkg::CFG_SRC_LF_MIN) begin
      decode_src = cssc_pkg::SRC_LOW_FREQ;
    end else if (c == cssc_pkg::CFG_SRC_RC_128K) begin
      decode_src = cssc_pkg::SRC_RC_128K;
    end else if (c == cssc_pkg::CFG_SRC_EXT) begin
      decode_src = cssc_pkg::SRC_EXTERNAL;
    end else begin
      decode_src = cssc_pkg::SRC_RC_CALIB;
    end
  endfunction

  // crystal rows step through short, long, none in threes of {bit0,sut}
  function automatic logic [15:0] decode_tout(
    input logic [3:0] c, input logic [1:0] s);
    logic [2:0] k;
    k = {c[0], s};
    if (c >= cssc_pkg::CFG_SRC_FS_MIN) begin
      case (k)
        3'h0, 3'h3, 3'h6: decode_tout = cssc_pkg::TOUT_SHORT;
        3'h1, 3'h4, 3'h7: decode_tout = cssc_pkg::TOUT_LONG;
        default:          decode_tout = cssc_pkg::TOUT_NONE;
      endcase
    end else begin
      case (s)
        2'h0:    decode_tout = cssc_pkg::TOUT_NONE;
        2'h1:    decode_tout = cssc_pkg::TOUT_SHORT;
        default: decode_tout = cssc_pkg::TOUT_LONG;
      endcase
    end
  endfunction

  // stabilisation count by oscillator family
  function automatic logic [15:0] decode_su(
    input logic [3:0] c, input logic [1:0] s);
    logic [2:0] k;
    k = {c[0], s};
    if (c >= cssc_pkg::CFG_SRC_FS_MIN) begin
      case (k)
        3'h0, 3'h1:       decode_su = cssc_pkg::SU_258;
        3'h2, 3'h3, 3'h4: decode_su = cssc_pkg::SU_1K;
        default:          decode_su = cssc_pkg::SU_16K;
      endcase
    end else if (c >= cssc_pkg::CFG_SRC_LF_MIN) begin
      decode_su = cssc_pkg::SU_32K;
    end else begin
      decode_su = cssc_pkg::SU_EXT;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // reset synchroniser and fuse capture

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= other_reset_n;
      rst_s2_q <= rst_s1_q;
    end
  end

  // fuses are caught while held, so a change mid-run has no effect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_on_q  <= (cssc_pkg::CFG_DIV8_DEFAULT == cssc_pkg::FUSE_PROGRAMMED);
      src_q     <= cssc_pkg::SRC_RC_CALIB;
      tout_q    <= cssc_pkg::TOUT_LONG;
      su_q      <= cssc_pkg::SU_EXT;
    end else if (state_q == cssc_pkg::ST_HOLD) begin
      // zero means programmed, so zero turns the divider on
      div_on_q  <= (divide_by_eight_setting == cssc_pkg::FUSE_PROGRAMMED);
      src_q     <= decode_src(clock_source_select);
      tout_q    <= decode_tout(clock_source_select, startup_time_select);
      su_q      <= decode_su(clock_source_select, startup_time_select);
    end
  end

  assign selected_source = src_q;

  //////////////////////////////////////////////////////////////////////////
  // oscillator selection and counters

  // muxing before the synchroniser is safe: src only moves in hold
  always_comb begin
    case (src_q)
      cssc_pkg::SRC_LOW_POWER:  osc_mux = xtal_osc;
      cssc_pkg::SRC_FULL_SWING: osc_mux = xtal_osc;
      cssc_pkg::SRC_LOW_FREQ:   osc_mux = lf_xtal_osc;
      cssc_pkg::SRC_RC_128K:    osc_mux = rc_128k_osc;
      cssc_pkg::SRC_EXTERNAL:   osc_mux = ext_clock;
      default:                  osc_mux = rc_calib_osc;
    endcase
  end

  assign async_mux = async_use_ext ? ext_clock : lf_xtal_osc;

  // supply time-out on the watchdog oscillator
  cssc_edge_counter #(.CNT_W(cssc_pkg::CNT_W)) u_wdt_cnt (
    .clk        (clk),
    .nrst       (nrst),
    .osc_in     (watchdog_osc),
    .clear      (state_q != cssc_pkg::ST_TIMEOUT),
    .target     (tout_q),
    .edge_pulse (),
    .done       (wdt_done)
  );

  // stabilisation count on the selected oscillator
  cssc_edge_counter #(.CNT_W(cssc_pkg::CNT_W)) u_osc_cnt (
    .clk        (clk),
    .nrst       (nrst),
    .osc_in     (osc_mux),
    .clear      (state_q != cssc_pkg::ST_STARTUP &&
                 state_q != cssc_pkg::ST_WAKE),
    .target     (su_q),
    .edge_pulse (osc_edge),
    .done       (osc_done)
  );

  // edge detector only; the count is never used
  cssc_edge_counter #(.CNT_W(cssc_pkg::CNT_W)) u_async_det (
    .clk        (clk),
    .nrst       (nrst),
    .osc_in     (async_mux),
    .clear      (1'b1),
    .target     (cssc_pkg::TOUT_NONE),
    .edge_pulse (async_edge),
    .done       ()
  );

  //////////////////////////////////////////////////////////////////////////
  // start-up sequencer

  assign deep = (mode_q == cssc_pkg::SLP_POWER_DOWN) ||
                (mode_q == cssc_pkg::SLP_POWER_SAVE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      cssc_pkg::ST_HOLD: begin
        if (rst_s2_q) state_d = cssc_pkg::ST_TIMEOUT;
      end
      cssc_pkg::ST_TIMEOUT: begin
        if (wdt_done) state_d = cssc_pkg::ST_STARTUP;
      end
      cssc_pkg::ST_STARTUP, cssc_pkg::ST_WAKE: begin
        // leave only on an oscillator edge so release is aligned
        if (osc_done && osc_edge) state_d = cssc_pkg::ST_RUN;
      end
      cssc_pkg::ST_RUN: begin
        if (sleep_req) state_d = cssc_pkg::ST_SLEEP;
      end
      cssc_pkg::ST_SLEEP: begin
        if (wake_req && deep) begin
          state_d = cssc_pkg::ST_WAKE;
        end else if (wake_req) begin
          state_d = cssc_pkg::ST_RUN;
        end
      end
      default: state_d = cssc_pkg::ST_HOLD;
    endcase
    if (!rst_s2_q) state_d = cssc_pkg::ST_HOLD;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= cssc_pkg::ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // sleep mode caught on entry
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= cssc_pkg::SLP_IDLE;
    end else if (state_q == cssc_pkg::ST_RUN && sleep_req) begin
      mode_q <= sleep_mode;
    end
  end

  // internal reset; wake from sleep does not reassert it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      internal_reset_n <= 1'b0;
    end else if (!rst_s2_q) begin
      internal_reset_n <= 1'b0;
    end else if (state_q == cssc_pkg::ST_STARTUP && osc_done && osc_edge) begin
      internal_reset_n <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // system clock divider and domain gating

  assign running = (state_q == cssc_pkg::ST_RUN) ||
                   (state_q == cssc_pkg::ST_SLEEP);

  // divider restarts on every release so the first tick is a full period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 3'h0;
    end else if (!running) begin
      div_q <= 3'h0;
    end else if (osc_edge) begin
      div_q <= div_q + 3'h1;
    end
  end

  assign tick = running && osc_edge &&
                (!div_on_q || div_q == cssc_pkg::DIV_LAST);

  assign io_on  = (state_q == cssc_pkg::ST_RUN) ||
                  (state_q == cssc_pkg::ST_SLEEP &&
                   mode_q == cssc_pkg::SLP_IDLE);
  assign adc_on = io_on ||
                  (state_q == cssc_pkg::ST_SLEEP &&
                   mode_q == cssc_pkg::SLP_ADC_NR);

  // every domain is a registered enable pulse; sleep drops the unused ones
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_clock              <= 1'b0;
      program_memory_clock    <= 1'b0;
      peripheral_clock        <= 1'b0;
      converter_clock         <= 1'b0;
      async_timer_clock       <= 1'b0;
      peripheral_clock_halted <= 1'b1;
    end else begin
      core_clock              <= tick && state_q == cssc_pkg::ST_RUN;
      program_memory_clock    <= tick && state_q == cssc_pkg::ST_RUN;
      peripheral_clock        <= tick && io_on;
      converter_clock         <= tick && adc_on;
      async_timer_clock       <= async_edge;
      peripheral_clock_halted <= !io_on;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_release;
    state_q == cssc_pkg::ST_STARTUP && osc_done && osc_edge && rst_s2_q;
  endsequence

  sequence s_deep_wake;
    state_q == cssc_pkg::ST_SLEEP && wake_req && deep && rst_s2_q;
  endsequence

  // second cycle in sleep: enables launched in sleep must be quiet
  sequence s_sleep_held;
    state_q == cssc_pkg::ST_SLEEP ##1 state_q == cssc_pkg::ST_SLEEP;
  endsequence

  chk_release_edge: assert property (@(posedge clk) disable iff (!nrst)
    s_release |=> internal_reset_n && state_q == cssc_pkg::ST_RUN)
    else $error("reset release not on oscillator edge");

  chk_no_early_release: assert property (@(posedge clk) disable iff (!nrst)
    $rose(internal_reset_n) |-> $past(state_q) == cssc_pkg::ST_STARTUP &&
      $past(osc_done))
    else $error("reset released before start-up count");

  chk_wake_skips_tout: assert property (@(posedge clk) disable iff (!nrst)
    s_deep_wake |=> state_q == cssc_pkg::ST_WAKE)
    else $error("deep wake did not go to start-up only");

  chk_tout_first: assert property (@(posedge clk) disable iff (!nrst)
    state_q == cssc_pkg::ST_STARTUP && $past(state_q) != state_q
      |-> $past(state_q) == cssc_pkg::ST_TIMEOUT && $past(wdt_done))
    else $error("start-up entered without time-out");

  chk_hold_on_reset: assert property (@(posedge clk) disable iff (!nrst)
    !rst_s2_q |=> state_q == cssc_pkg::ST_HOLD && !internal_reset_n)
    else $error("reset source ignored");

  chk_div_eight: assert property (@(posedge clk) disable iff (!nrst)
    tick && div_on_q |-> div_q == 3'h7 ##1 div_q == 3'h0)
    else $error("divide by eight tick misplaced");

  chk_fuse_polarity: assert property (@(posedge clk) disable iff (!nrst)
    state_q == cssc_pkg::ST_HOLD
      |=> div_on_q == !$past(divide_by_eight_setting))
    else $error("divider fuse polarity wrong");

  chk_flash_core: assert property (@(posedge clk) disable iff (!nrst)
    program_memory_clock == core_clock)
    else $error("program memory clock split from core");

  chk_core_halt: assert property (@(posedge clk) disable iff (!nrst)
    s_sleep_held |-> !core_clock && !program_memory_clock)
    else $error("core clock running in sleep");

  chk_async_sleep: assert property (@(posedge clk) disable iff (!nrst)
    async_edge && state_q == cssc_pkg::ST_SLEEP |=> async_timer_clock)
    else $error("async timer clock stopped in sleep");

  chk_reserved_src: assert property (@(posedge clk) disable iff (!nrst)
    state_q == cssc_pkg::ST_HOLD &&
      clock_source_select == cssc_pkg::CFG_SRC_RESERVED
      |=> src_q == cssc_pkg::SRC_RC_CALIB)
    else $error("reserved source code decoded wrong");

endmodule
`default_nettype wire

// [tb/cssc_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cssc_osc_model (
  // oscillator pins
  output logic xtal_osc,
  output logic lf_xtal_osc,
  output logic rc_calib_osc,
  output logic rc_128k_osc,
  output logic ext_clock,
  output logic watchdog_osc
);
  // all sources start low so edge counts begin cleanly
  initial begin
    xtal_osc     = 1'b0;
    lf_xtal_osc  = 1'b0;
    rc_calib_osc = 1'b0;
    rc_128k_osc  = 1'b0;
    ext_clock    = 1'b0;
    watchdog_osc = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // free running, each period above 20 ns so the 2-flop sync keeps up;
  // only ext_clock, at 30 ns, is a whole clk multiple; the 1.25 ns lag
  // keeps every pin edge off both clk edges, so no count races a check
  always #11 xtal_osc <= #1.25 ~xtal_osc;
  always #13 lf_xtal_osc <= #1.25 ~lf_xtal_osc;
  always #12 rc_calib_osc <= #1.25 ~rc_calib_osc;
  always #14 rc_128k_osc <= #1.25 ~rc_128k_osc;
  always #15 ext_clock <= #1.25 ~ext_clock;
  always #12 watchdog_osc <= #1.25 ~watchdog_osc;
endmodule
`default_nettype wire

// [tb/cssc_clock_startup_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module cssc_clock_startup_tb_top;
  logic       clk, nrst, other_reset_n, divide_by_eight_setting;
  logic       async_use_ext, sleep_req, wake_req;
  logic [3:0] clock_source_select;
  logic [1:0] startup_time_select;
  logic [2:0] sleep_mode, selected_source;
  logic       xtal_osc, lf_xtal_osc, rc_calib_osc, rc_128k_osc;
  logic       ext_clock, watchdog_osc, internal_reset_n, core_clock;
  logic       program_memory_clock, peripheral_clock, async_timer_clock;
  logic       converter_clock, peripheral_clock_halted;
  int         errors, checks_done;
  int         n_wd, n_xt, n_lf, n_ext, n_rc, n_core, n_pm, n_per, n_conv, n_asy;
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  //////////////////////////////////////////////////////////////////////////
  // clock, 200 MHz
  always #2.5 clk = ~clk;
  // oscillator sources
  cssc_osc_model osc (
    .xtal_osc(xtal_osc), .lf_xtal_osc(lf_xtal_osc),
    .rc_calib_osc(rc_calib_osc), .rc_128k_osc(rc_128k_osc),
    .ext_clock(ext_clock), .watchdog_osc(watchdog_osc));
  cssc_clock_startup uut (
    .clk(clk), .nrst(nrst), .other_reset_n(other_reset_n),
    .clock_source_select(clock_source_select),
    .startup_time_select(startup_time_select),
    .divide_by_eight_setting(divide_by_eight_setting),
    .async_use_ext(async_use_ext), .xtal_osc(xtal_osc),
    .lf_xtal_osc(lf_xtal_osc), .rc_calib_osc(rc_calib_osc),
    .rc_128k_osc(rc_128k_osc), .ext_clock(ext_clock),
    .watchdog_osc(watchdog_osc), .sleep_req(sleep_req),
    .sleep_mode(sleep_mode), .wake_req(wake_req),
    .internal_reset_n(internal_reset_n), .core_clock(core_clock),
    .program_memory_clock(program_memory_clock),
    .peripheral_clock(peripheral_clock),
    .async_timer_clock(async_timer_clock),
    .converter_clock(converter_clock),
    .peripheral_clock_halted(peripheral_clock_halted),
    .selected_source(selected_source));
  //////////////////////////////////////////////////////////////////////////
  // edge counters; pin edges never coincide with falling clk edges
  always @(posedge watchdog_osc) n_wd++;
  always @(posedge xtal_osc) n_xt++;
  always @(posedge lf_xtal_osc) n_lf++;
  always @(posedge ext_clock) n_ext++;
  always @(posedge rc_calib_osc) n_rc++;
  // enable pulses last one cycle, so sample each rising edge
  always @(posedge clk) begin
    if (core_clock === 1'b1) n_core++;
    if (program_memory_clock === 1'b1) n_pm++;
    if (peripheral_clock === 1'b1) n_per++;
    if (converter_clock === 1'b1) n_conv++;
    if (async_timer_clock === 1'b1) n_asy++;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      errors++;
      $display("ERROR %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic clr();
    {n_wd, n_xt, n_lf, n_ext, n_rc} = '0;
    {n_core, n_pm, n_per, n_conv, n_asy} = '0;
  endtask
  // bounded wait for release (sel 0) or a core tick (sel 1)
  task automatic wait_hi(input bit sel, input int limit);
    int n;
    n = 0;
    while ((sel ? core_clock : internal_reset_n) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > limit) begin
        errors++;
        $display("ERROR %0t: wait ran out", $time);
        end_sim();
      end
    end
  endtask
  // full start-up: fuses are taken only while other reset holds
  task automatic boot(input logic [3:0] c, input logic [1:0] s,
                      input logic d);
    @(negedge clk);
    other_reset_n = 1'b0;
    clock_source_select = c;
    startup_time_select = s;
    divide_by_eight_setting = d;
    repeat (6) @(negedge clk);
    check_val(internal_reset_n, 16'h0000);
    clr();
    other_reset_n = 1'b1;
    wait_hi(1'b0, 60000);
    check_rng(n_core, 0, 0);
  endtask
  function automatic logic [15:0] exp_src(input int c);
    if (c >= 8) return 16'h0000;
    if (c >= 6) return 16'h0001;
    if (c >= 4) return 16'h0002;
    if (c == 3) return 16'h0003;
    if (c == 0) return 16'h0005;
    return 16'h0004;
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    other_reset_n = 1'b0;
    clock_source_select = 4'h2;
    startup_time_select = 2'h2;
    divide_by_eight_setting = 1'b0;
    async_use_ext = 1'b1;
    sleep_req = 1'b0;
    sleep_mode = 3'h0;
    wake_req = 1'b0;
    errors = 0;
    checks_done = 0;
    clr();
    repeat (16) @(negedge clk);
    check_val(internal_reset_n, 16'h0000);
    check_val(peripheral_clock_halted, 16'h0001);
    check_val(selected_source, 16'h0004);
    nrst = 1'b1;
    for (int c = 0; c < 16; c++) begin
      clock_source_select = c[3:0];
      repeat (4) @(negedge clk);
      check_val(selected_source, exp_src(c));
    end
    // shipped setting; long time-out outlasts any supply rise
    boot(4'h2, 2'h2, 1'b0);
    check_rng(n_wd, 8192, 8206);
    clr();
    repeat (800) @(negedge clk);
    check_rng(n_rc - 8 * n_core, -8, 16);
    check_rng(n_pm - n_core, 0, 0);
    // internal 128k source, short time-out
    boot(4'h3, 2'h1, 1'b1);
    check_rng(n_wd, 4096, 4110);
    // crystal with zero time-out and 1K start-up count
    boot(4'h6, 2'h2, 1'b1);
    check_rng(n_xt, 1024, 1028);
    // applied clock, no time-out, undivided
    boot(4'h0, 2'h0, 1'b1);
    check_rng(n_ext, 6, 9);
    check_rng(n_wd, 0, 20);
    clr();
    repeat (600) @(negedge clk);
    check_rng(n_ext - n_core, -1, 2);
    check_rng(n_per - n_core, 0, 0);
    check_rng(n_conv - n_core, 0, 0);
    // each sleep mode, then wake
    foreach (modes[i]) begin
      sleep_mode = modes[i];
      sleep_req = 1'b1;
      @(negedge clk);
      sleep_req = 1'b0;
      repeat (2) @(negedge clk);
      clr();
      repeat (300) @(negedge clk);
      check_rng(n_core + n_pm, 0, 0);
      check_rng(n_per, i == 0 ? 20 : 0, i == 0 ? 99 : 0);
      check_rng(n_conv, i <= 1 ? 20 : 0, i <= 1 ? 99 : 0);
      check_val(peripheral_clock_halted, {15'h0000, i != 0});
      check_rng(n_asy - n_ext, -1, 1);
      clr();
      wake_req = 1'b1;
      @(negedge clk);
      wake_req = 1'b0;
      wait_hi(1'b1, 2000);
      if (i == 2 || i == 3) check_rng(n_ext, 6, 9);
      else check_rng(n_ext, 0, 2);
      check_val(internal_reset_n, 16'h0001);
    end
    // async timer from the low-frequency crystal instead
    async_use_ext = 1'b0;
    @(negedge clk);
    clr();
    repeat (300) @(negedge clk);
    check_rng(n_asy - n_lf, -1, 1);
    end_sim();
  end
endmodule
`default_nettype wire
